// ===== verilog/core_alu_branch_exec.sv
// execution datapath: byte/word arithmetic, logic, multiply, flow
`timescale 1ns/1ns

module core_alu_branch_exec (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    req_valid,
  input  wire alu_exec_pkg::exec_req_t req,
  output logic                         req_ready,
  output alu_exec_pkg::exec_res_t      res,
  output logic                         res_valid,
  output logic [7:0]                   flags,
  output logic [15:0]                  pc
);

  // ==========================================================
  // operand selection and byte arithmetic
  logic        take;
  logic [7:0]  opnd;
  logic        cin;
  logic        is_sub;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic [7:0]  lres;
  logic        logic_op;
  logic        arith_op;
  logic [7:0]  flags_ff;
  logic [15:0] pc_ff;

  assign take     = req_valid && req_ready;
  assign opnd     = req.use_imm ? req.imm : req.rr;
  assign cin      = (req.op == alu_exec_pkg::OP_ADC
                  || req.op == alu_exec_pkg::OP_SBC) ? flags_ff[0] : 1'b0;
  assign is_sub   = req.op == alu_exec_pkg::OP_SUB
                  || req.op == alu_exec_pkg::OP_SBC;
  // add and subtract each form sum9; on subtract bit 8 is the borrow itself, not inverted
  assign sum9  = is_sub ? ({1'b0, req.rd} - {1'b0, opnd} - {8'h00, cin})
                        : ({1'b0, req.rd} + {1'b0, opnd}
                           + {8'h00, cin});
  assign half5 = is_sub ? ({1'b0, req.rd[3:0]} - {1'b0, opnd[3:0]}
                           - {4'h0, cin})
                        : ({1'b0, req.rd[3:0]} + {1'b0, opnd[3:0]}
                           + {4'h0, cin});
  assign arith_op = req.op inside {alu_exec_pkg::OP_ADD,
                    alu_exec_pkg::OP_ADC, alu_exec_pkg::OP_SUB,
                    alu_exec_pkg::OP_SBC};
  assign logic_op = req.op inside {alu_exec_pkg::OP_AND,
                    alu_exec_pkg::OP_OR, alu_exec_pkg::OP_XOR,
                    alu_exec_pkg::OP_SETB, alu_exec_pkg::OP_CLRB,
                    alu_exec_pkg::OP_TEST};

  // logic unit; clear uses the mask's inverse 0xFF minus mask
  always_comb begin
    case (req.op)
      alu_exec_pkg::OP_AND:  lres = req.rd & opnd;
      alu_exec_pkg::OP_OR:   lres = req.rd | opnd;
      alu_exec_pkg::OP_XOR:  lres = req.rd ^ req.rr;
      alu_exec_pkg::OP_SETB: lres = req.rd | req.imm;
      alu_exec_pkg::OP_CLRB: lres = req.rd & (8'hFF - req.imm);
      alu_exec_pkg::OP_TEST: lres = req.rd & req.rd;
      default:               lres = req.rd;
    endcase
  end

  // byte overflow from operand and result signs
  logic        byte_v;
  assign byte_v = is_sub
    ? (req.rd[7] & ~opnd[7] & ~sum9[7]) | (~req.rd[7] & opnd[7] & sum9[7])
    : (req.rd[7] & opnd[7] & ~sum9[7]) | (~req.rd[7] & ~opnd[7] & sum9[7]);

  // ==========================================================
  // word and multiply results, computed at acceptance and held for the second cycle
  logic        is_word;
  logic        is_mul;
  logic        is_frac;
  logic        a_sgn;
  logic        b_sgn;
  logic [16:0] wsum;
  logic [31:0] prod_full;
  logic [15:0] prod_raw;

  assign is_word = req.op == alu_exec_pkg::OP_WADD
                || req.op == alu_exec_pkg::OP_WSUB;
  assign is_mul  = req.op inside {alu_exec_pkg::OP_MULU,
                   alu_exec_pkg::OP_SIGNED_PRODUCT, alu_exec_pkg::OP_MIXED_SIGN_PRODUCT,
                   alu_exec_pkg::OP_FMULU, alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT,
                   alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT};
  assign is_frac = req.op inside {alu_exec_pkg::OP_FMULU,
                   alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT};
  assign a_sgn   = req.op inside {alu_exec_pkg::OP_SIGNED_PRODUCT,
                   alu_exec_pkg::OP_MIXED_SIGN_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT,
                   alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT};
  assign b_sgn   = req.op == alu_exec_pkg::OP_SIGNED_PRODUCT
                || req.op == alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT;
  assign wsum = (req.op == alu_exec_pkg::OP_WSUB)
              ? {1'b0, req.word} - {9'h000, req.imm}
              : {1'b0, req.word} + {9'h000, req.imm};
  // sign-extend each factor per variant, keep low 16 bits
  assign prod_full = {{24{a_sgn & req.rd[7]}}, req.rd}
                   * {{24{b_sgn & req.rr[7]}}, req.rr};
  assign prod_raw  = prod_full[15:0];

  // ==========================================================
  // flow control targets
  logic [15:0] pc_next;
  logic [15:0] rel_target;
  logic        equal;

  assign pc_next    = pc_ff + alu_exec_pkg::PC_STEP;
  assign rel_target = pc_ff + {{4{req.offset[11]}}, req.offset}
                    + alu_exec_pkg::PC_STEP;
  assign equal      = req.rd == req.rr;

  // ==========================================================
  // sequencer: holds off the decoder for multi-cycle work
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} st_t;
  st_t         st_ff;
  st_t         nxt_st;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  logic [1:0]  cyc;
  logic [7:0]  nxt_flags;
  logic [15:0] nxt_pc;
  alu_exec_pkg::exec_res_t res_ff;
  alu_exec_pkg::exec_res_t nxt_res;
  alu_exec_pkg::exec_res_t pend_ff;
  alu_exec_pkg::exec_res_t nxt_pend;
  logic [7:0]  pend_flags_ff;
  logic [7:0]  nxt_pend_flags;
  logic        res_valid_ff;
  logic        nxt_res_valid;

  assign req_ready = (st_ff == ST_IDLE);

  // cycles needed by the incoming instruction
  always_comb begin
    cyc = 2'h1;
    if (is_word) cyc = alu_exec_pkg::CYC_WORD;
    else if (is_mul) cyc = alu_exec_pkg::CYC_MUL;
    else if (req.op == alu_exec_pkg::OP_INDIRECT_JUMP_VIA_POINTER) cyc = alu_exec_pkg::CYC_JMP;
    else if (req.op == alu_exec_pkg::OP_RELATIVE_SUBROUTINE_CALL
          || req.op == alu_exec_pkg::OP_INDIRECT_SUBROUTINE_CALL) cyc = alu_exec_pkg::CYC_CALL;
    else if (req.op == alu_exec_pkg::OP_COMPARE_AND_SKIP_EQUAL && equal)
      cyc = req.next_two_words ? 2'h3 : 2'h2;
  end

  // result and flags are computed at acceptance, released at the end
  always_comb begin
    nxt_pend       = '0;
    nxt_pend_flags = flags_ff;
    nxt_pend.pc_we = 1'b1;
    nxt_pend.pc_val = pc_next;
    if (arith_op) begin
      nxt_pend.byte_we  = 1'b1;
      nxt_pend.byte_val = sum9[7:0];
      nxt_pend_flags[alu_exec_pkg::FLAG_C] = sum9[8];
      nxt_pend_flags[alu_exec_pkg::FLAG_Z] = sum9[7:0] == 8'h00;
      nxt_pend_flags[alu_exec_pkg::FLAG_N] = sum9[7];
      nxt_pend_flags[alu_exec_pkg::FLAG_V] = byte_v;
      nxt_pend_flags[alu_exec_pkg::FLAG_H] = half5[4];
    end else if (logic_op) begin
      // carry and half-carry stay as they were
      nxt_pend.byte_we  = req.op != alu_exec_pkg::OP_TEST;
      nxt_pend.byte_val = lres;
      nxt_pend_flags[alu_exec_pkg::FLAG_Z] = lres == 8'h00;
      nxt_pend_flags[alu_exec_pkg::FLAG_N] = lres[7];
      nxt_pend_flags[alu_exec_pkg::FLAG_V] = 1'b0;
    end else if (is_word) begin
      nxt_pend.word_we  = 1'b1;
      nxt_pend.word_val = wsum[15:0];
      nxt_pend_flags[alu_exec_pkg::FLAG_C] = wsum[16];
      nxt_pend_flags[alu_exec_pkg::FLAG_Z] = wsum[15:0] == 16'h0000;
      nxt_pend_flags[alu_exec_pkg::FLAG_N] = wsum[15];
      nxt_pend_flags[alu_exec_pkg::FLAG_V] =
        (req.op == alu_exec_pkg::OP_WSUB) ? (req.word[15] & ~wsum[15])
                                          : (~req.word[15] & wsum[15]);
      nxt_pend_flags[alu_exec_pkg::FLAG_S] = wsum[15]
        ^ ((req.op == alu_exec_pkg::OP_WSUB) ? (req.word[15] & ~wsum[15])
                                             : (~req.word[15] & wsum[15]));
    end else if (is_mul) begin
      nxt_pend.word_we  = 1'b1;
      nxt_pend.prod     = 1'b1;
      nxt_pend.word_val = is_frac ? {prod_raw[14:0], 1'b0}
                                  : prod_raw;
      nxt_pend_flags[alu_exec_pkg::FLAG_C] = prod_raw[15];
      nxt_pend_flags[alu_exec_pkg::FLAG_Z] =
        (is_frac ? {prod_raw[14:0], 1'b0} : prod_raw) == 16'h0000;
    end else if (req.op == alu_exec_pkg::OP_INDIRECT_JUMP_VIA_POINTER) begin
      nxt_pend.pc_val = req.word;
    end else if (req.op == alu_exec_pkg::OP_RELATIVE_SUBROUTINE_CALL
              || req.op == alu_exec_pkg::OP_INDIRECT_SUBROUTINE_CALL) begin
      nxt_pend.push_we  = 1'b1;
      nxt_pend.push_val = pc_next;
      nxt_pend.pc_val   = (req.op == alu_exec_pkg::OP_INDIRECT_SUBROUTINE_CALL)
                        ? req.word : rel_target;
    end else if (req.op == alu_exec_pkg::OP_COMPARE_AND_SKIP_EQUAL && equal) begin
      nxt_pend.pc_val = pc_ff + {14'h0000, cyc};
    end
  end

  // sequencing: single-cycle ops retire now, others after count
  always_comb begin
    nxt_st        = st_ff;
    nxt_cnt       = cnt_ff;
    nxt_res       = res_ff;
    nxt_res_valid = 1'b0;
    nxt_flags     = flags_ff;
    nxt_pc        = pc_ff;
    case (st_ff)
      ST_IDLE: begin
        if (take && cyc == 2'h1) begin
          nxt_res       = nxt_pend;
          nxt_res_valid = 1'b1;
          nxt_flags     = nxt_pend_flags;
          nxt_pc        = nxt_pend.pc_val;
        end else if (take) begin
          nxt_st  = ST_BUSY;
          nxt_cnt = cyc - 2'h2;
        end
      end
      ST_BUSY: begin
        if (cnt_ff == 2'h0) begin
          nxt_st        = ST_IDLE;
          nxt_res       = pend_ff;
          nxt_res_valid = 1'b1;
          nxt_flags     = pend_flags_ff;
          nxt_pc        = pend_ff.pc_val;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff         <= ST_IDLE;
      cnt_ff        <= 2'h0;
      flags_ff      <= alu_exec_pkg::FLAGS_RESET;
      pc_ff         <= alu_exec_pkg::PC_RESET;
      res_ff        <= '0;
      res_valid_ff  <= 1'b0;
      pend_ff       <= '0;
      pend_flags_ff <= alu_exec_pkg::FLAGS_RESET;
    end else begin
      st_ff         <= nxt_st;
      cnt_ff        <= nxt_cnt;
      flags_ff      <= nxt_flags;
      pc_ff         <= nxt_pc;
      res_ff        <= nxt_res;
      res_valid_ff  <= nxt_res_valid;
      if (take) pend_ff <= nxt_pend;
      if (take) pend_flags_ff <= nxt_pend_flags;
    end
  end

  assign res       = res_ff;
  assign res_valid = res_valid_ff;
  assign flags     = flags_ff;
  assign pc        = pc_ff;

  // ==========================================================
  // checks
  sequence two_cyc_s;
    req_valid && req_ready
    && (is_mul || is_word || req.op == alu_exec_pkg::OP_INDIRECT_JUMP_VIA_POINTER);
  endsequence

  add_result_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && req.op == alu_exec_pkg::OP_ADD |=> res_valid
    && res.byte_val == $past(req.rd + req.rr))
    else $error("add result wrong");
  word_timing_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && is_word |=> !res_valid ##1 res_valid && res.word_we)
    else $error("word op timing wrong");
  sub_carry_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && req.op == alu_exec_pkg::OP_SUB |=>
    flags[0] == ($past(req.rd) < $past(opnd)))
    else $error("subtract borrow wrong");
  logic_keep_c_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && logic_op |=> flags[0] == $past(flags[0])
    && flags[5] == $past(flags[5]))
    else $error("logic op touched carry");
  clear_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && req.op == alu_exec_pkg::OP_CLRB |=>
    (res.byte_val & $past(req.imm)) == 8'h00)
    else $error("clear bits failed");
  mul_ready_a: assert property (@(posedge clock) disable iff (!rst_n)
    two_cyc_s |=> !req_ready ##1 req_ready)
    else $error("multi cycle hold wrong");
  call_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && req.op == alu_exec_pkg::OP_INDIRECT_SUBROUTINE_CALL |=>
    !res_valid [*2] ##1 res_valid && res.push_we)
    else $error("indirect call timing wrong");
  jump_target_a: assert property (@(posedge clock) disable iff (!rst_n)
    take && req.op == alu_exec_pkg::OP_INDIRECT_JUMP_VIA_POINTER |=> ##1
    pc == $past(req.word, 2))
    else $error("indirect jump target wrong");

endmodule : core_alu_branch_exec

// ===== verilog/alu_exec_pkg.sv
// shared types and constants for the core execution datapath
package alu_exec_pkg;

  // ==========================================================
  // operation codes issued by the decoder
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_WADD, OP_SUB, OP_SBC, OP_WSUB,
    OP_AND, OP_OR, OP_XOR, OP_SETB, OP_CLRB, OP_TEST,
    OP_MULU, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FMULU, OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT,
    OP_RELATIVE_SUBROUTINE_CALL, OP_INDIRECT_JUMP_VIA_POINTER, OP_INDIRECT_SUBROUTINE_CALL, OP_COMPARE_AND_SKIP_EQUAL
  } op_t;

  // ==========================================================
  // status flag positions in the status byte
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET   = 16'h0000;

  // ==========================================================
  // cycle counts per instruction class
  localparam logic [1:0] CYC_WORD = 2'h2;
  localparam logic [1:0] CYC_MUL  = 2'h2;
  localparam logic [1:0] CYC_JMP  = 2'h2;
  localparam logic [1:0] CYC_CALL = 2'h3;
  localparam logic [15:0] PC_STEP = 16'h0001;

  // ==========================================================
  // request from decoder and register file
  typedef struct packed {
    op_t         op;
    logic [7:0]  rd;      // destination operand
    logic [7:0]  rr;      // source register operand
    logic [7:0]  imm;     // immediate constant or mask
    logic        use_imm; // take imm instead of rr for add, subtract, and, or
    logic [15:0] word;    // register pair, or pointer pair
    logic [11:0] offset;  // signed relative call offset
    logic        next_two_words; // skipped instruction length
  } exec_req_t;

  // results written back
  typedef struct packed {
    logic        byte_we;
    logic [7:0]  byte_val;
    logic        word_we;  // register pair or product pair
    logic        prod;     // word target is the product pair
    logic [15:0] word_val;
    logic        push_we;
    logic [15:0] push_val;
    logic        pc_we;
    logic [15:0] pc_val;
  } exec_res_t;

endpackage : alu_exec_pkg

// ===== tb/exec_feed_model.sv
// decoder and register file stand-in that offers one request at a time
`timescale 1ns/1ns

module exec_feed_model (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    go,
  input  wire alu_exec_pkg::exec_req_t next_req,
  input  wire logic                    req_ready,
  output logic                         req_valid,
  output alu_exec_pkg::exec_req_t      req
);
  // ==========================================================
  // offer held until taken at a ready edge; released fields are
  // inverted so a stale value cannot pass for a live one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else if (go) begin
      req_valid <= 1'b1;
      req       <= next_req;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req       <= alu_exec_pkg::exec_req_t'(~req);
    end
  end
endmodule : exec_feed_model

// ===== tb/core_alu_branch_exec_tb.sv
// self-checking bench for the execution datapath
`timescale 1ns/1ns

module core_alu_branch_exec_tb;

  // ==========================================================
  // clock, reset, partner model and the block under test
  logic                    clock = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    go = 1'b0;
  alu_exec_pkg::exec_req_t next_req = '0;
  alu_exec_pkg::exec_req_t req;
  logic                    req_valid;
  logic                    req_ready;
  alu_exec_pkg::exec_res_t res;
  logic                    res_valid;
  logic [7:0]              flags;
  logic [15:0]             pc;
  int                      bad_count = 0;
  int                      checks_done = 0;

  // 8 ns period
  always #4 clock = ~clock;

  exec_feed_model feed_u (
    .clock     (clock),
    .rst_n     (rst_n),
    .go        (go),
    .next_req  (next_req),
    .req_ready (req_ready),
    .req_valid (req_valid),
    .req       (req)
  );

  core_alu_branch_exec dut_u (
    .clock     (clock),
    .rst_n     (rst_n),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .res       (res),
    .res_valid (res_valid),
    .flags     (flags),
    .pc        (pc)
  );

  // ==========================================================
  // one compare point for every check
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // offer one request, wait for retirement, count the cycles
  task automatic issue(input alu_exec_pkg::exec_req_t r, input int cyc);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    next_req = r;
    go       = 1'b1;
    @(posedge clock);
    #1;
    go = 1'b0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (!res_valid && n < 8);
    check("retire cycles", n, cyc);
    check("retire pulse", res_valid, 1'b1);
  endtask : issue

  // byte operand goes to rr or imm; the unused one is its inverse
  task automatic byte_op(input alu_exec_pkg::op_t op, input logic [7:0] a,
                         input logic [7:0] b, input logic ui,
                         input int cyc);
    alu_exec_pkg::exec_req_t r;
    r         = '0;
    r.op      = op;
    r.rd      = a;
    r.rr      = ui ? ~b : b;
    r.imm     = ui ? b : ~b;
    r.use_imm = ui;
    issue(r, cyc);
  endtask : byte_op

  // word, pointer, offset and skip requests
  task automatic wide_op(input alu_exec_pkg::op_t op, input logic [15:0] w,
                         input logic [7:0] k8, input logic [11:0] k,
                         input logic [7:0] b, input logic two,
                         input int cyc);
    alu_exec_pkg::exec_req_t r;
    r                = '0;
    r.op             = op;
    r.rd             = 8'h5A;
    r.rr             = b;
    r.imm            = k8;
    r.word           = w;
    r.offset         = k;
    r.next_two_words = two;
    issue(r, cyc);
  endtask : wide_op

  // ==========================================================
  // scenarios
  task automatic t_add;
    byte_op(alu_exec_pkg::OP_ADD, 8'h0F, 8'h01, 1'b0, 1);
    check("add half", {res.byte_val, flags}, {8'h10, 8'h20});
    byte_op(alu_exec_pkg::OP_ADD, 8'hFF, 8'h01, 1'b0, 1);
    check("add wrap", {res.byte_val, flags}, {8'h00, 8'h23});
    byte_op(alu_exec_pkg::OP_ADC, 8'h10, 8'h20, 1'b0, 1);
    check("add carry", {res.byte_val, flags}, {8'h31, 8'h00});
    byte_op(alu_exec_pkg::OP_ADD, 8'h7F, 8'h01, 1'b0, 1);
    check("add ovf", {res.byte_val, flags}, {8'h80, 8'h2C});
    check("add write", {res.byte_we, pc}, {1'b1, 16'h0004});
  endtask : t_add

  task automatic t_sub;
    byte_op(alu_exec_pkg::OP_SUB, 8'h10, 8'h01, 1'b0, 1);
    check("sub reg", {res.byte_val, flags}, {8'h0F, 8'h20});
    byte_op(alu_exec_pkg::OP_SUB, 8'h01, 8'h02, 1'b1, 1);
    check("sub const", {res.byte_val, flags}, {8'hFF, 8'h25});
    byte_op(alu_exec_pkg::OP_SBC, 8'h80, 8'h01, 1'b1, 1);
    check("sbc const", {res.byte_val, flags}, {8'h7E, 8'h28});
    byte_op(alu_exec_pkg::OP_SUB, 8'h00, 8'h01, 1'b0, 1);
    check("sub borrow", {res.byte_val, flags}, {8'hFF, 8'h25});
    byte_op(alu_exec_pkg::OP_SBC, 8'h05, 8'h02, 1'b0, 1);
    check("sbc reg", {res.byte_val, flags}, {8'h02, 8'h00});
  endtask : t_sub

  task automatic t_logic;
    byte_op(alu_exec_pkg::OP_ADD, 8'hFF, 8'h01, 1'b0, 1);
    check("set c h", flags, 8'h23);
    byte_op(alu_exec_pkg::OP_AND, 8'hF0, 8'h3C, 1'b0, 1);
    check("and reg", {res.byte_val, flags}, {8'h30, 8'h21});
    byte_op(alu_exec_pkg::OP_AND, 8'h0F, 8'hF0, 1'b1, 1);
    check("and const", {res.byte_val, flags}, {8'h00, 8'h23});
    byte_op(alu_exec_pkg::OP_OR, 8'h80, 8'h01, 1'b0, 1);
    check("or reg", {res.byte_val, flags}, {8'h81, 8'h25});
    byte_op(alu_exec_pkg::OP_OR, 8'h00, 8'h00, 1'b1, 1);
    check("or const", {res.byte_val, flags}, {8'h00, 8'h23});
    byte_op(alu_exec_pkg::OP_XOR, 8'hAA, 8'hFF, 1'b0, 1);
    check("xor", {res.byte_val, flags}, {8'h55, 8'h21});
    byte_op(alu_exec_pkg::OP_SETB, 8'h01, 8'h80, 1'b1, 1);
    check("set bits", {res.byte_val, flags}, {8'h81, 8'h25});
    byte_op(alu_exec_pkg::OP_CLRB, 8'hFF, 8'h0F, 1'b1, 1);
    check("clear bits", {res.byte_val, flags}, {8'hF0, 8'h25});
    byte_op(alu_exec_pkg::OP_TEST, 8'h00, 8'h00, 1'b0, 1);
    check("test", {res.byte_we, flags}, {1'b0, 8'h23});
  endtask : t_logic

  task automatic t_word;
    wide_op(alu_exec_pkg::OP_WADD, 16'h00FF, 8'h01, 12'h000, 8'h00, 1'b0, 2);
    check("wadd", {res.word_val, flags}, {16'h0100, 8'h20});
    check("wadd pair", {res.word_we, res.prod}, 2'b10);
    wide_op(alu_exec_pkg::OP_WADD, 16'h7FFF, 8'h01, 12'h000, 8'h00, 1'b0, 2);
    check("wadd ovf", {res.word_val, flags}, {16'h8000, 8'h2C});
    wide_op(alu_exec_pkg::OP_WSUB, 16'h0000, 8'h01, 12'h000, 8'h00, 1'b0, 2);
    check("wsub wrap", {res.word_val, flags}, {16'hFFFF, 8'h35});
    wide_op(alu_exec_pkg::OP_WSUB, 16'h0001, 8'h01, 12'h000, 8'h00, 1'b0, 2);
    check("wsub zero", {res.word_val, flags}, {16'h0000, 8'h22});
  endtask : t_word

  task automatic t_mul;
    byte_op(alu_exec_pkg::OP_MULU, 8'hFF, 8'hFF, 1'b0, 2);
    check("mulu", {res.word_val, flags}, {16'hFE01, 8'h21});
    check("mul pair", {res.word_we, res.prod}, 2'b11);
    byte_op(alu_exec_pkg::OP_SIGNED_PRODUCT, 8'hFF, 8'h02, 1'b0, 2);
    check("signed_product", {res.word_val, flags}, {16'hFFFE, 8'h21});
    byte_op(alu_exec_pkg::OP_MIXED_SIGN_PRODUCT, 8'hFF, 8'hFF, 1'b0, 2);
    check("mixed_sign_product", {res.word_val, flags}, {16'hFF01, 8'h21});
    byte_op(alu_exec_pkg::OP_FMULU, 8'h80, 8'h80, 1'b0, 2);
    check("fmulu", {res.word_val, flags}, {16'h8000, 8'h20});
    byte_op(alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, 8'hC0, 8'h40, 1'b0, 2);
    check("fractional_signed_product", {res.word_val, flags}, {16'hE000, 8'h21});
    byte_op(alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT, 8'h00, 8'h55, 1'b0, 2);
    check("fractional_mixed_product", {res.word_val, flags}, {16'h0000, 8'h22});
    check("mul pc", pc, 16'h001C);
  endtask : t_mul

  task automatic t_flow;
    wide_op(alu_exec_pkg::OP_RELATIVE_SUBROUTINE_CALL, 16'h0000, 8'h00, 12'h010, 8'h00, 1'b0, 3);
    check("relative_subroutine_call push", {res.push_we, res.push_val}, 17'h1001D);
    check("relative_subroutine_call pc", {pc, flags}, {16'h002D, 8'h22});
    wide_op(alu_exec_pkg::OP_RELATIVE_SUBROUTINE_CALL, 16'h0000, 8'h00, 12'hFFE, 8'h00, 1'b0, 3);
    check("relative_subroutine_call back", {res.push_val, pc}, {16'h002E, 16'h002C});
    wide_op(alu_exec_pkg::OP_INDIRECT_JUMP_VIA_POINTER, 16'h1234, 8'h00, 12'h000, 8'h00, 1'b0, 2);
    check("indirect_jump_via_pointer pc", {res.push_we, pc, flags}, {1'b0, 16'h1234, 8'h22});
    wide_op(alu_exec_pkg::OP_INDIRECT_SUBROUTINE_CALL, 16'h0100, 8'h00, 12'h000, 8'h00, 1'b0, 3);
    check("indirect_subroutine_call push", {res.push_we, res.push_val}, 17'h11235);
    check("indirect_subroutine_call pc", {pc, flags}, {16'h0100, 8'h22});
    wide_op(alu_exec_pkg::OP_COMPARE_AND_SKIP_EQUAL, 16'h0000, 8'h00, 12'h000, 8'h5B, 1'b0, 1);
    check("compare_and_skip_equal ne", {pc, flags}, {16'h0101, 8'h22});
    wide_op(alu_exec_pkg::OP_COMPARE_AND_SKIP_EQUAL, 16'h0000, 8'h00, 12'h000, 8'h5A, 1'b0, 2);
    check("compare_and_skip_equal one", pc, 16'h0103);
    wide_op(alu_exec_pkg::OP_COMPARE_AND_SKIP_EQUAL, 16'h0000, 8'h00, 12'h000, 8'h5A, 1'b1, 3);
    check("compare_and_skip_equal two", pc, 16'h0106);
  endtask : t_flow

  // reset in mid-run, then the first request straight after
  task automatic t_reset;
    @(posedge clock);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("reset state", {flags, pc}, 24'h000000);
    check("reset idle", {req_ready, res_valid}, 2'b10);
    rst_n = 1'b1;
    byte_op(alu_exec_pkg::OP_ADD, 8'h01, 8'h02, 1'b0, 1);
    check("after reset", {res.byte_val, flags}, {8'h03, 8'h00});
    check("after pc", pc, 16'h0001);
  endtask : t_reset

  // ==========================================================
  // verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // ceiling far above the fewer than 150 cycles the scenarios need
  initial begin
    fork
      begin
        repeat (6) @(posedge clock);
        #1;
        check("start state", {flags, pc}, 24'h000000);
        check("start idle", {req_ready, res_valid}, 2'b10);
        rst_n = 1'b1;
        t_add();
        t_sub();
        t_logic();
        t_word();
        t_mul();
        t_flow();
        t_reset();
      end
      begin
        repeat (5000) @(posedge clock);
        bad_count++;
      end
    join_any
    final_report();
  end

endmodule : core_alu_branch_exec_tb
